// ---- core/mfb_consts.svh ----
`ifndef MFB_CONSTS_SVH
`define MFB_CONSTS_SVH

// Byte offsets of the bank locations; the word address on the bus is 4x.
`define MFB_STEP_RATE_LOW        8'h34
`define MFB_STEP_RATE_HIGH       8'h35
`define MFB_SIGMOTION_RATE_LOW   8'h36
`define MFB_SIGMOTION_RATE_HIGH  8'h37
`define MFB_BRING_VIEW_RATE_LOW  8'h38
`define MFB_BRING_VIEW_RATE_HIGH 8'h39
`define MFB_JOLT_RATE_LOW        8'h3A
`define MFB_JOLT_RATE_HIGH       8'h3B
`define MFB_STILLNESS_RATE_LOW   8'h3C
`define MFB_STILLNESS_RATE_HIGH  8'h3D
`define MFB_LEVEL_RATE_LOW       8'h3E
`define MFB_LEVEL_RATE_HIGH      8'h3F
`define MFB_ORIENT_RESET         8'h62
`define MFB_INCLINE_RESET        8'h63
`define MFB_STEP_PACE            8'h79
`define MFB_GAIT_CLASS           8'h7A
`define MFB_STEP_TOTAL_A_LOW     8'h7C
`define MFB_STEP_TOTAL_A_HIGH    8'h7D
`define MFB_STEP_TOTAL_B_LOW     8'h7E
`define MFB_STEP_TOTAL_B_HIGH    8'h7F
`define MFB_FALL_LENGTH_A_LOW    8'h88
`define MFB_FALL_LENGTH_A_HIGH   8'h89
`define MFB_FALL_LENGTH_B_LOW    8'h8A
`define MFB_FALL_LENGTH_B_HIGH   8'h8B
`define MFB_KNOCK_TYPE           8'h8E
`define MFB_KNOCK_AXIS           8'h8F
`define MFB_IRQ_STATUS           8'hC0
`define MFB_IRQ_ENABLE           8'hC1
`define MFB_IRQ_CLEAR            8'hC2
`define MFB_INIT_CTRL            8'hC3

// Interrupt status bit positions.
`define MFB_EV_STEP              0
`define MFB_EV_FALL              1
`define MFB_EV_KNOCK             2
`define MFB_EV_TILT_DONE         3
`define MFB_EV_BITS              4

// Rate loaded by the initialisation command, and the value that arms a reset request.
`define MFB_RATE_DEFAULT         16'h0032
`define MFB_REQUEST_ON           8'h01

`endif

// ---- core/mfb_pkg.sv ----
package mfb_pkg;

    typedef struct packed {
        logic [7:0] step_lo;
        logic [7:0] step_hi;
        logic [7:0] sig_lo;
        logic [7:0] sig_hi;
        logic [7:0] bring_lo;
        logic [7:0] bring_hi;
        logic [7:0] jolt_lo;
        logic [7:0] jolt_hi;
        logic [7:0] still_lo;
        logic [7:0] still_hi;
        logic [7:0] level_lo;
        logic [7:0] level_hi;
        logic [7:0] orient_req;
        logic [7:0] incline_req;
        logic [7:0] step_pace;
        logic [7:0] gait_class;
        logic [15:0] step_total_a;
        logic [15:0] step_total_b;
        logic [15:0] fall_a;
        logic [15:0] fall_b;
        logic [7:0] knock_type;
        logic [7:0] knock_axis;
        logic       step_sel;
        logic       fall_sel;
        logic [3:0] irq_status;
        logic [3:0] irq_enable;
        logic       ack;
        logic [31:0] rdata;
        logic       irq;
        logic       tilt_reset;
        logic       orient_reset;
        logic       initialised;
    } mfb_state_t;

endpackage

// ---- core/mfb_bank.sv ----
`timescale 1ns/1ps
`include "mfb_consts.svh"
// How it works
// - Bank holds no meaningful data until the engine initialise command runs.
// - Step rate is signed 16-bit hertz, default 50, low byte first.
// - Significant-motion rate is signed 16-bit hertz over two bytes, default 50.
// - Bring-to-see rate is signed 16-bit hertz over two bytes, default 50.
// - Shake rate is signed 16-bit hertz over two bytes, default 50.
// - No-motion rate is signed 16-bit hertz over two bytes, default 50.
// - Flat rate is signed 16-bit hertz over two bytes, default 50.
// - Orientation reset value 1 resets quaternion only with tilt reset also 1.
// - Tilt reset value 1 resets tilt state before next sample's processing.
// - Step pace is four times the samples between two steps.
// - Gait class: 0 unknown, 1 walking, 2 running.
// - Step total written alternately into buffer A and buffer B.
// - Fall length written alternately into buffer A and buffer B.
// - Knock type: 0 none, 1 single, 2 double, 3 triple.
module mfb_bank (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    input  wire logic        sample_i,
    input  wire logic        step_valid_i,
    input  wire logic [7:0]  step_pace_i,
    input  wire logic [1:0]  gait_class_i,
    input  wire logic [15:0] step_total_i,
    input  wire logic        fall_valid_i,
    input  wire logic [15:0] fall_length_i,
    input  wire logic        knock_valid_i,
    input  wire logic [1:0]  knock_type_i,
    input  wire logic [1:0]  knock_axis_i,
    output logic      [15:0] step_feature_rate_o,
    output logic      [15:0] sigmotion_feature_rate_o,
    output logic      [15:0] bring_view_feature_rate_o,
    output logic      [15:0] jolt_feature_rate_o,
    output logic      [15:0] stillness_feature_rate_o,
    output logic      [15:0] level_feature_rate_o,
    output logic             tilt_reset_o,
    output logic             orientation_reset_o,
    output logic             initialised_o
);

    mfb_pkg::mfb_state_t state;
    mfb_pkg::mfb_state_t next_state;

    logic [7:0] offset;
    logic       req;
    logic       wr_byte;
    logic [7:0] wbyte;
    logic [3:0] events;

    // Held whole here; each rate byte takes its own slice of it when loaded.
    localparam logic [15:0] rate_default = `MFB_RATE_DEFAULT;

    assign offset  = wb_adr_i[9:2];
    assign req     = wb_cyc_i && wb_stb_i && !state.ack;
    assign wr_byte = req && wb_we_i && wb_sel_i[0];
    assign wbyte   = wb_dat_i[7:0];

    // Reads return the byte in the low lane; unmapped offsets read zero.
    function automatic logic [7:0] read_byte(
        input mfb_pkg::mfb_state_t s,
        input logic [7:0]          off
    );
        logic [7:0] v;
        v = 8'h00;
        unique case (off)
            `MFB_STEP_RATE_LOW:        v = s.step_lo;
            `MFB_STEP_RATE_HIGH:       v = s.step_hi;
            `MFB_SIGMOTION_RATE_LOW:   v = s.sig_lo;
            `MFB_SIGMOTION_RATE_HIGH:  v = s.sig_hi;
            `MFB_BRING_VIEW_RATE_LOW:  v = s.bring_lo;
            `MFB_BRING_VIEW_RATE_HIGH: v = s.bring_hi;
            `MFB_JOLT_RATE_LOW:        v = s.jolt_lo;
            `MFB_JOLT_RATE_HIGH:       v = s.jolt_hi;
            `MFB_STILLNESS_RATE_LOW:   v = s.still_lo;
            `MFB_STILLNESS_RATE_HIGH:  v = s.still_hi;
            `MFB_LEVEL_RATE_LOW:       v = s.level_lo;
            `MFB_LEVEL_RATE_HIGH:      v = s.level_hi;
            `MFB_ORIENT_RESET:         v = s.orient_req;
            `MFB_INCLINE_RESET:        v = s.incline_req;
            `MFB_STEP_PACE:            v = s.step_pace;
            `MFB_GAIT_CLASS:           v = s.gait_class;
            `MFB_STEP_TOTAL_A_LOW:     v = s.step_total_a[7:0];
            `MFB_STEP_TOTAL_A_HIGH:    v = s.step_total_a[15:8];
            `MFB_STEP_TOTAL_B_LOW:     v = s.step_total_b[7:0];
            `MFB_STEP_TOTAL_B_HIGH:    v = s.step_total_b[15:8];
            `MFB_FALL_LENGTH_A_LOW:    v = s.fall_a[7:0];
            `MFB_FALL_LENGTH_A_HIGH:   v = s.fall_a[15:8];
            `MFB_FALL_LENGTH_B_LOW:    v = s.fall_b[7:0];
            `MFB_FALL_LENGTH_B_HIGH:   v = s.fall_b[15:8];
            `MFB_KNOCK_TYPE:           v = s.knock_type;
            `MFB_KNOCK_AXIS:           v = s.knock_axis;
            `MFB_IRQ_STATUS:           v = {4'h0, s.irq_status};
            `MFB_IRQ_ENABLE:           v = {4'h0, s.irq_enable};
            `MFB_INIT_CTRL:            v = {7'h00, s.initialised};
            default:                   v = 8'h00;
        endcase
        return v;
    endfunction

    always_comb begin
        next_state = state;
        events     = 4'h0;
        next_state.tilt_reset   = 1'b0;
        next_state.orient_reset = 1'b0;

        // The engine's results land whole, so a host never sees half a pair.
        if (step_valid_i) begin
            next_state.step_pace  = step_pace_i;
            next_state.gait_class = {6'h00, gait_class_i};
            if (state.step_sel) begin
                next_state.step_total_b = step_total_i;
            end else begin
                next_state.step_total_a = step_total_i;
            end
            next_state.step_sel = !state.step_sel;
            events[`MFB_EV_STEP] = 1'b1;
        end
        if (fall_valid_i) begin
            if (state.fall_sel) begin
                next_state.fall_b = fall_length_i;
            end else begin
                next_state.fall_a = fall_length_i;
            end
            next_state.fall_sel = !state.fall_sel;
            events[`MFB_EV_FALL] = 1'b1;
        end
        if (knock_valid_i) begin
            next_state.knock_type = {6'h00, knock_type_i};
            next_state.knock_axis = {6'h00, knock_axis_i};
            events[`MFB_EV_KNOCK] = 1'b1;
        end

        // The request is consumed by the sample it acts on, as a one-shot.
        if (sample_i && state.incline_req == `MFB_REQUEST_ON) begin
            next_state.tilt_reset  = 1'b1;
            next_state.incline_req = 8'h00;
            if (state.orient_req == `MFB_REQUEST_ON) begin
                next_state.orient_reset = 1'b1;
                next_state.orient_req   = 8'h00;
            end
            events[`MFB_EV_TILT_DONE] = 1'b1;
        end

        next_state.ack   = req;
        next_state.rdata = {24'h000000, read_byte(state, offset)};
        if (wr_byte) begin
            unique case (offset)
                `MFB_STEP_RATE_LOW:        next_state.step_lo = wbyte;
                `MFB_STEP_RATE_HIGH:       next_state.step_hi = wbyte;
                `MFB_SIGMOTION_RATE_LOW:   next_state.sig_lo = wbyte;
                `MFB_SIGMOTION_RATE_HIGH:  next_state.sig_hi = wbyte;
                `MFB_BRING_VIEW_RATE_LOW:  next_state.bring_lo = wbyte;
                `MFB_BRING_VIEW_RATE_HIGH: next_state.bring_hi = wbyte;
                `MFB_JOLT_RATE_LOW:        next_state.jolt_lo = wbyte;
                `MFB_JOLT_RATE_HIGH:       next_state.jolt_hi = wbyte;
                `MFB_STILLNESS_RATE_LOW:   next_state.still_lo = wbyte;
                `MFB_STILLNESS_RATE_HIGH:  next_state.still_hi = wbyte;
                `MFB_LEVEL_RATE_LOW:       next_state.level_lo = wbyte;
                `MFB_LEVEL_RATE_HIGH:      next_state.level_hi = wbyte;
                `MFB_ORIENT_RESET:         next_state.orient_req = wbyte;
                `MFB_INCLINE_RESET:        next_state.incline_req = wbyte;
                `MFB_STEP_PACE:            next_state.step_pace = wbyte;
                `MFB_GAIT_CLASS:           next_state.gait_class = wbyte;
                `MFB_STEP_TOTAL_A_LOW:     next_state.step_total_a[7:0] = wbyte;
                `MFB_STEP_TOTAL_A_HIGH:    next_state.step_total_a[15:8] = wbyte;
                `MFB_STEP_TOTAL_B_LOW:     next_state.step_total_b[7:0] = wbyte;
                `MFB_STEP_TOTAL_B_HIGH:    next_state.step_total_b[15:8] = wbyte;
                `MFB_FALL_LENGTH_A_LOW:    next_state.fall_a[7:0] = wbyte;
                `MFB_FALL_LENGTH_A_HIGH:   next_state.fall_a[15:8] = wbyte;
                `MFB_FALL_LENGTH_B_LOW:    next_state.fall_b[7:0] = wbyte;
                `MFB_FALL_LENGTH_B_HIGH:   next_state.fall_b[15:8] = wbyte;
                `MFB_KNOCK_TYPE:           next_state.knock_type = wbyte;
                `MFB_KNOCK_AXIS:           next_state.knock_axis = wbyte;
                `MFB_IRQ_ENABLE:
                    next_state.irq_enable = wbyte[3:0];
                `MFB_IRQ_CLEAR:
                    next_state.irq_status = state.irq_status & ~wbyte[3:0];
                `MFB_INIT_CTRL: begin
                    if (wbyte[0]) begin
                        next_state.step_lo  = rate_default[7:0];
                        next_state.step_hi  = rate_default[15:8];
                        next_state.sig_lo   = rate_default[7:0];
                        next_state.sig_hi   = rate_default[15:8];
                        next_state.bring_lo = rate_default[7:0];
                        next_state.bring_hi = rate_default[15:8];
                        next_state.jolt_lo  = rate_default[7:0];
                        next_state.jolt_hi  = rate_default[15:8];
                        next_state.still_lo = rate_default[7:0];
                        next_state.still_hi = rate_default[15:8];
                        next_state.level_lo = rate_default[7:0];
                        next_state.level_hi = rate_default[15:8];
                        next_state.orient_req   = 8'h00;
                        next_state.incline_req  = 8'h00;
                        next_state.step_pace    = 8'h00;
                        next_state.gait_class   = 8'h00;
                        next_state.step_total_a = 16'h0000;
                        next_state.step_total_b = 16'h0000;
                        next_state.fall_a       = 16'h0000;
                        next_state.fall_b       = 16'h0000;
                        next_state.knock_type   = 8'h00;
                        next_state.knock_axis   = 8'h00;
                        next_state.step_sel     = 1'b0;
                        next_state.fall_sel     = 1'b0;
                        next_state.initialised  = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // New events win over a clear arriving in the same cycle.
        next_state.irq_status = next_state.irq_status | events;
        next_state.irq = |(next_state.irq_status & next_state.irq_enable);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Data bytes are zeroed only for determinism; until init they
            // carry no meaning and software must not rely on them.
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign wb_dat_o                  = state.rdata;
    assign wb_ack_o                  = state.ack;
    assign irq_o                     = state.irq;
    assign step_feature_rate_o       = {state.step_hi, state.step_lo};
    assign sigmotion_feature_rate_o  = {state.sig_hi, state.sig_lo};
    assign bring_view_feature_rate_o = {state.bring_hi, state.bring_lo};
    assign jolt_feature_rate_o       = {state.jolt_hi, state.jolt_lo};
    assign stillness_feature_rate_o  = {state.still_hi, state.still_lo};
    assign level_feature_rate_o      = {state.level_hi, state.level_lo};
    assign tilt_reset_o              = state.tilt_reset;
    assign orientation_reset_o       = state.orient_reset;
    assign initialised_o             = state.initialised;

endmodule

// ---- tb/mfb_bank_checker.sv ----
`timescale 1ns/1ps
module mfb_bank_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        sample_i,
    input wire logic [15:0] step_feature_rate_o,
    input wire logic [15:0] level_feature_rate_o,
    input wire logic        tilt_reset_o,
    input wire logic        orientation_reset_o,
    input wire logic        initialised_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_idle;
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
    endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack unasked");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_upper;
        wb_ack_o |-> wb_dat_o[31:8] == 24'h000000;
    endproperty
    a_upper: assert property (p_upper) else $error("read upper not zero");
    property p_tilt_cause;
        tilt_reset_o |-> $past(sample_i);
    endproperty
    a_tilt_cause: assert property (p_tilt_cause) else $error("tilt no sample");
    property p_tilt_pulse;
        tilt_reset_o |=> !tilt_reset_o;
    endproperty
    a_tilt_pulse: assert property (p_tilt_pulse) else $error("tilt repeats");
    property p_orient_tilt;
        orientation_reset_o |-> tilt_reset_o;
    endproperty
    a_orient_tilt: assert property (p_orient_tilt) else $error("orient alone");
    property p_reset_clear;
        $fell(rst_i) |-> step_feature_rate_o == 16'h0000 && !initialised_o;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset dirty");
    property p_init_default;
        $rose(initialised_o) |-> step_feature_rate_o == 16'h0032
            && level_feature_rate_o == 16'h0032;
    endproperty
    a_init_default: assert property (p_init_default) else $error("bad default");
    property p_rate_cause;
        $changed({step_feature_rate_o, level_feature_rate_o})
            |-> $past(wb_cyc_i && wb_stb_i && wb_we_i);
    endproperty
    a_rate_cause: assert property (p_rate_cause) else $error("rate moved");
    c_write: cover property (wb_ack_o && wb_we_i);
    c_tilt: cover property (tilt_reset_o);
    c_orient: cover property (orientation_reset_o);
    c_init: cover property ($rose(initialised_o));
endmodule
bind mfb_bank mfb_bank_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sample_i(sample_i),
    .step_feature_rate_o(step_feature_rate_o),
    .level_feature_rate_o(level_feature_rate_o),
    .tilt_reset_o(tilt_reset_o), .orientation_reset_o(orientation_reset_o),
    .initialised_o(initialised_o));

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic       we;
        logic [7:0] off;
        logic [7:0] wd;
        logic [7:0] exp;
    } mfb_row_t;
    localparam mfb_row_t ROWS [8] = '{
        '{1'b1, 8'h34, 8'hFF, 8'h00}, '{1'b1, 8'h35, 8'h7F, 8'h00},
        '{1'b0, 8'h34, 8'h00, 8'hFF}, '{1'b0, 8'h35, 8'h00, 8'h7F},
        '{1'b1, 8'h3F, 8'h80, 8'h00}, '{1'b0, 8'h3F, 8'h00, 8'h80},
        '{1'b1, 8'h50, 8'hA5, 8'h00}, '{1'b0, 8'h50, 8'h00, 8'h00}};
    logic        clk_i, rst_i, cyc, stb, we, irq_o, ack, tilt, orient, init;
    logic [9:0]  adr;
    logic [31:0] wdat, rdat;
    logic [3:0]  ev;
    logic [7:0]  pace, rd;
    logic [1:0]  gait, ktype, kaxis;
    logic [15:0] total, fall;
    logic [15:0] rate [6];
    int          n_mismatch, n_compared;
    mfb_bank dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq_o),
        .sample_i(ev[3]), .step_valid_i(ev[0]), .step_pace_i(pace),
        .gait_class_i(gait), .step_total_i(total), .fall_valid_i(ev[1]),
        .fall_length_i(fall), .knock_valid_i(ev[2]),
        .knock_type_i(ktype), .knock_axis_i(kaxis),
        .step_feature_rate_o(rate[0]), .sigmotion_feature_rate_o(rate[1]),
        .bring_view_feature_rate_o(rate[2]), .jolt_feature_rate_o(rate[3]),
        .stillness_feature_rate_o(rate[4]), .level_feature_rate_o(rate[5]),
        .tilt_reset_o(tilt), .orientation_reset_o(orient),
        .initialised_o(init));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    task automatic end_of_test;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Reads ack and data before the edge's own updates land.
    task automatic bus(input logic w, input logic [7:0] o, input logic [7:0] d);
        cyc <= 1'b1; stb <= 1'b1; we <= w;
        adr <= {o, 2'b00}; wdat <= {24'h000000, d};
        // Only the watchdog ends a wait for an answer that never comes.
        do @(posedge clk_i); while (ack !== 1'b1);
        rd = rdat[7:0];
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rdchk(input logic [7:0] o, input logic [7:0] e);
        bus(1'b0, o, 8'h00);
        chk(rd, e);
    endtask
    task automatic pulse(input logic [3:0] m);
        ev <= m;
        @(posedge clk_i);
        ev <= 4'h0;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic samp(input logic [1:0] e);
        ev <= 4'h8;
        @(posedge clk_i);
        ev <= 4'h0;
        // The pulses stand for the one cycle before this edge.
        @(posedge clk_i);
        chk({tilt, orient}, e);
        @(posedge clk_i);
    endtask
    initial begin
        #20000 n_mismatch++;
        end_of_test;
    end
    initial begin
        n_mismatch = 0; n_compared = 0; rst_i = 1'b1; cyc = 1'b0; stb = 1'b0;
        we = 1'b0; adr = '0; wdat = '0; ev = '0; pace = '0; gait = '0;
        ktype = '0; kaxis = '0; total = '0; fall = '0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk(init, 1'b0);
        chk(rate[0], 16'h0000);
        bus(1'b1, 8'hC3, 8'h01);
        chk(init, 1'b1);
        foreach (rate[k]) chk(rate[k], 16'h0032);
        for (int i = 0; i < 12; i++)
            rdchk(8'(8'h34 + i), i[0] ? 8'h00 : 8'h32);
        foreach (ROWS[k]) begin
            bus(ROWS[k].we, ROWS[k].off, ROWS[k].wd);
            if (!ROWS[k].we) chk(rd, ROWS[k].exp);
        end
        chk(rate[0], 16'h7FFF);
        chk(rate[5], 16'h8032);
        bus(1'b1, 8'hC1, 8'h00);
        pace <= 8'h28; gait <= 2'd2; total <= 16'h1234;
        pulse(4'h1);
        chk(irq_o, 1'b0);
        rdchk(8'hC0, 8'h01);
        bus(1'b1, 8'hC1, 8'h0F);
        chk(irq_o, 1'b1);
        rdchk(8'h79, 8'h28);
        rdchk(8'h7A, 8'h02);
        rdchk(8'h7C, 8'h34);
        rdchk(8'h7D, 8'h12);
        gait <= 2'd1; total <= 16'h5678;
        pulse(4'h1);
        rdchk(8'h7A, 8'h01);
        rdchk(8'h7E, 8'h78);
        rdchk(8'h7F, 8'h56);
        rdchk(8'h7C, 8'h34);
        gait <= 2'd0; total <= 16'h9ABC;
        pulse(4'h1);
        rdchk(8'h7A, 8'h00);
        rdchk(8'h7D, 8'h9A);
        fall <= 16'h8001;
        pulse(4'h2);
        fall <= 16'h0102;
        pulse(4'h2);
        rdchk(8'h89, 8'h80);
        rdchk(8'h8A, 8'h02);
        rdchk(8'h8B, 8'h01);
        for (int t = 0; t < 4; t++) begin
            ktype <= 2'(t); kaxis <= 2'(t % 3);
            pulse(4'h4);
            rdchk(8'h8E, 8'(t));
            rdchk(8'h8F, 8'(t % 3));
        end
        rdchk(8'hC0, 8'h07);
        bus(1'b1, 8'hC2, 8'h07);
        chk(irq_o, 1'b0);
        bus(1'b1, 8'h62, 8'h01);
        bus(1'b1, 8'h63, 8'h01);
        samp(2'b11);
        rdchk(8'hC0, 8'h08);
        chk(irq_o, 1'b1);
        rdchk(8'h63, 8'h00);
        bus(1'b1, 8'h62, 8'h01);
        samp(2'b00);
        rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk(init, 1'b0);
        chk(rate[0], 16'h0000);
        chk(irq_o, 1'b0);
        end_of_test;
    end
endmodule
